// ---- pkg/sao_pkg.sv ----
// constants and types for the setpoint alarm output block
package sao_pkg;
   localparam int VAL_W = 18;
   localparam int CNT_W = 16;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SETPT = 8'h04;
   localparam logic [7:0] ADDR_HYST = 8'h08;
   localparam logic [7:0] ADDR_ONDLY = 8'h0c;
   localparam logic [7:0] ADDR_OFFDLY = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQST = 8'h18;
   localparam logic [7:0] ADDR_IRQMSK = 8'h1c;
   localparam logic [7:0] ADDR_CMD = 8'h20;
   // control field positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_ACT = 1;
   localparam int CTRL_RMODE = 3;
   localparam int CTRL_STBY = 5;
   localparam int CTRL_CFOL = 6;
   localparam int CTRL_RDR = 7;
   localparam int CTRL_DSRC = 8;
   localparam int CTRL_BASECOL = 9;
   localparam int CTRL_W = 10;
   // status and interrupt bits
   localparam int STAT_OUT = 0;
   localparam int STAT_PEND = 1;
   localparam int STAT_STBY = 2;
   localparam int STAT_HOLD = 3;
   localparam int STAT_COL = 4;
   localparam int IRQ_ON = 0;
   localparam int IRQ_OFF = 1;
   localparam int IRQ_RST = 2;
   localparam int IRQ_W = 3;
   // value ranges and reset values
   localparam int SP_MAX = 99999;
   localparam int SP_MIN = -19999;
   localparam int HYS_MIN = 1;
   localparam int HYS_MAX = 59999;
   localparam int DLY_MAX = 59999;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [VAL_W-1:0] SP_RST = 18'h00000;
   localparam logic [CNT_W-1:0] HYS_RST = 16'h0001;
   localparam logic [CNT_W-1:0] DLY_RST = 16'h0000;
   // delay ticks are tenths of a second
   localparam longint CLK_PERIOD_PS = 5000;
   localparam longint TENTH_PS = 64'h0000_0017_4876_e800;
   localparam int TENTH_CYCLES = int'(TENTH_PS / CLK_PERIOD_PS);
   typedef enum logic [1:0] {
      high_act_balanced,
      low_act_balanced,
      high_act_unbalanced,
      low_act_unbalanced
   } sao_action_t;
   typedef enum logic [1:0] {
      auto_clear,
      latch_now_clear,
      latch_deferred_clear,
      spare_clear
   } sao_rmode_t;
endpackage : sao_pkg

// ---- rtl/sao_delay.sv ----
// tenth-second delay timer used for on and off postponement
`timescale 1ns/1ps
module sao_delay #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // timing
   input wire logic tenthTick,
   input wire logic arm,
   input wire logic [CNT_W-1:0] limit,
   // result
   output logic expired
);
   logic [CNT_W-1:0] cntReg;
   logic [CNT_W-1:0] cntNext;
   wire atLimit = (cntReg >= limit);

   assign cntNext = !arm ? '0 : (tenthTick && !atLimit) ? cntReg + 1'b1 : cntReg;
   assign expired = arm && atLimit;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cntReg <= '0;
      end else begin
         cntReg <= cntNext;
      end
   end

   property p_restart;
      @(posedge sys_clk) disable iff (!rst_n) !arm |-> !expired ##1 (cntReg == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("delay timer did not restart");

   property p_count;
      @(posedge sys_clk) disable iff (!rst_n) arm && tenthTick && !atLimit ##1 arm |-> cntReg == $past(cntReg) + 1'b1;
   endproperty
   a_count: assert property (p_count) else $error("delay timer missed a tick");
endmodule : sao_delay

// ---- rtl/sao_top.sv ----
// setpoint alarm output with ahb-lite register access
`timescale 1ns/1ps
module sao_top #(
   parameter int TENTH_CYCLES = sao_pkg::TENTH_CYCLES,
   parameter int VAL_W = sao_pkg::VAL_W,
   parameter int CNT_W = sao_pkg::CNT_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // measurement and panel
   input wire logic signed [VAL_W-1:0] dispValue,
   input wire logic measTick,
   input wire logic rstButton,
   input wire logic userReset,
   input wire logic dispReset,
   input wire logic dispShowsInput,
   // outputs
   output logic alarmOut,
   output logic backlightColour,
   output logic irq
);
   typedef enum logic [2:0] {ST_INIT, ST_STBY, ST_OFF, ST_ON, ST_HOLD} sao_state_t;

   function automatic logic [31:0] clampVal(input logic signed [31:0] x, input int lo, input int hi);
      clampVal = (x < lo) ? lo : (x > hi) ? hi : x;
   endfunction : clampVal

   logic [sao_pkg::CTRL_W-1:0] ctrlReg;
   logic signed [VAL_W-1:0] spReg;
   logic [CNT_W-1:0] hysReg;
   logic [CNT_W-1:0] onDlyReg;
   logic [CNT_W-1:0] offDlyReg;
   logic [sao_pkg::IRQ_W-1:0] irqStReg;
   logic [sao_pkg::IRQ_W-1:0] irqStNext;
   logic [sao_pkg::IRQ_W-1:0] irqMskReg;
   logic wrPendReg;
   logic [7:0] wrAddrReg;
   logic serialReg;
   logic btnReg;
   logic btnPrevReg;
   logic usrReg;
   logic usrPrevReg;
   logic onLvlReg;
   logic offLvlReg;
   logic pendReg;
   logic pendNext;
   logic [31:0] tickCntReg;
   logic tenthTick;
   sao_state_t stReg;
   sao_state_t stNext;

   // bus decode
   wire addrPhase = hsel && htrans[1] && hready && (hsize == 3'b010);
   wire [7:0] aOff = haddr[7:0];
   wire wrEn = wrPendReg;
   wire signed [31:0] wVal = $signed(hwdata);
   logic [31:0] rdMux;
   assign rdMux = (aOff == sao_pkg::ADDR_CTRL) ? 32'(ctrlReg) :
                  (aOff == sao_pkg::ADDR_SETPT) ? 32'(signed'(spReg)) :
                  (aOff == sao_pkg::ADDR_HYST) ? 32'(hysReg) :
                  (aOff == sao_pkg::ADDR_ONDLY) ? 32'(onDlyReg) :
                  (aOff == sao_pkg::ADDR_OFFDLY) ? 32'(offDlyReg) :
                  (aOff == sao_pkg::ADDR_STATUS) ? {27'h0, backlightColour, stReg == ST_HOLD,
                                                    stReg == ST_STBY, pendReg, alarmOut} :
                  (aOff == sao_pkg::ADDR_IRQST) ? 32'(irqStReg) :
                  (aOff == sao_pkg::ADDR_IRQMSK) ? 32'(irqMskReg) : 32'h0;

   // control fields
   wire enBit = ctrlReg[sao_pkg::CTRL_EN];
   wire [1:0] actBits = ctrlReg[sao_pkg::CTRL_ACT +: 2];
   wire [1:0] rmBits = ctrlReg[sao_pkg::CTRL_RMODE +: 2];
   wire stbyBit = ctrlReg[sao_pkg::CTRL_STBY];
   wire cfolBit = ctrlReg[sao_pkg::CTRL_CFOL];
   wire rdrBit = ctrlReg[sao_pkg::CTRL_RDR];
   wire dsrcBit = ctrlReg[sao_pkg::CTRL_DSRC];
   wire baseCol = ctrlReg[sao_pkg::CTRL_BASECOL];
   wire isHigh = (actBits == sao_pkg::high_act_balanced) || (actBits == sao_pkg::high_act_unbalanced);
   wire isBal = (actBits == sao_pkg::high_act_balanced) || (actBits == sao_pkg::low_act_balanced);
   wire rmAuto = (rmBits == sao_pkg::auto_clear);
   wire rmNow = (rmBits == sao_pkg::latch_now_clear) || (rmBits == sao_pkg::spare_clear);
   wire rmDefer = (rmBits == sao_pkg::latch_deferred_clear);

   // trigger points
   wire signed [19:0] vExt = 20'(dispValue);
   wire signed [19:0] spExt = 20'(spReg);
   wire signed [19:0] hExt = signed'({4'h0, hysReg});
   wire signed [19:0] balExt = isBal ? hExt : 20'sh0;
   wire signed [19:0] onPt = isHigh ? spExt + balExt : spExt - balExt;
   wire signed [19:0] offPt = isHigh ? spExt - hExt : spExt + hExt;
   wire onCond = isHigh ? (vExt >= onPt) : (vExt <= onPt);
   wire offCond = isHigh ? (vExt <= offPt) : (vExt >= offPt);

   // manual reset sources
   wire btnPress = btnReg && !btnPrevReg;
   wire usrPress = usrReg && !usrPrevReg;
   wire dispRstEvt = dispReset && rdrBit && dsrcBit && dispShowsInput;
   wire manualReq = btnPress || usrPress || serialReg || dispRstEvt;

   // delay timers
   wire onDone;
   wire offDone;
   assign tenthTick = (tickCntReg == 32'(TENTH_CYCLES - 1));

   sao_delay #(.CNT_W(CNT_W)) uOnDly (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tenthTick(tenthTick),
      .arm((stReg == ST_OFF) && onLvlReg),
      .limit(onDlyReg),
      .expired(onDone)
   );

   sao_delay #(.CNT_W(CNT_W)) uOffDly (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tenthTick(tenthTick),
      .arm((stReg == ST_ON) && offLvlReg),
      .limit(offDlyReg),
      .expired(offDone)
   );

   // output state machine
   always_comb begin
      stNext = stReg;
      pendNext = pendReg;
      if (!enBit) begin
         stNext = (stReg == ST_INIT) ? ST_INIT : ST_OFF;
         pendNext = 1'b0;
      end else begin
         case (stReg)
            ST_INIT: begin
               stNext = stbyBit ? ST_STBY : ST_OFF;
            end
            ST_STBY: begin
               if (offLvlReg) begin
                  stNext = ST_OFF;
               end
            end
            ST_OFF: begin
               if (onDone) begin
                  stNext = ST_ON;
               end
            end
            ST_ON: begin
               if (rmAuto) begin
                  if (manualReq) begin
                     stNext = ST_HOLD;
                  end else if (offDone) begin
                     stNext = ST_OFF;
                  end
               end else if (rmNow) begin
                  if (manualReq) begin
                     stNext = ST_HOLD;
                  end
               end else if ((pendReg || manualReq) && offDone) begin
                  stNext = ST_OFF;
                  pendNext = 1'b0;
               end else if (manualReq) begin
                  pendNext = 1'b1;
               end
            end
            ST_HOLD: begin
               if (offLvlReg) begin
                  stNext = ST_OFF;
               end
            end
            default: begin
               stNext = ST_OFF;
            end
         endcase
      end
   end

   // interrupt events, set wins over clear
   wire goOn = (stNext == ST_ON) && (stReg != ST_ON);
   wire goOff = (stReg == ST_ON) && (stNext != ST_ON);
   wire rstTaken = manualReq && (stReg == ST_ON);
   wire [sao_pkg::IRQ_W-1:0] irqSet = {rstTaken, goOff, goOn};
   wire [sao_pkg::IRQ_W-1:0] irqClr = (wrEn && wrAddrReg == sao_pkg::ADDR_IRQST) ?
                                      hwdata[sao_pkg::IRQ_W-1:0] : '0;
   assign irqStNext = (irqStReg & ~irqClr) | irqSet;

   // bus slave and registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPendReg <= 1'b0;
         wrAddrReg <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wrPendReg <= addrPhase && hwrite;
         wrAddrReg <= aOff;
         hrdata <= (addrPhase && !hwrite) ? rdMux : 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlReg <= sao_pkg::CTRL_RST;
         spReg <= sao_pkg::SP_RST;
         hysReg <= sao_pkg::HYS_RST;
         onDlyReg <= sao_pkg::DLY_RST;
         offDlyReg <= sao_pkg::DLY_RST;
         irqMskReg <= '0;
         serialReg <= 1'b0;
      end else begin
         serialReg <= wrEn && (wrAddrReg == sao_pkg::ADDR_CMD) && hwdata[0];
         if (wrEn && wrAddrReg == sao_pkg::ADDR_CTRL) begin
            ctrlReg <= hwdata[sao_pkg::CTRL_W-1:0];
         end
         if (wrEn && wrAddrReg == sao_pkg::ADDR_SETPT) begin
            spReg <= VAL_W'(clampVal(wVal, sao_pkg::SP_MIN, sao_pkg::SP_MAX));
         end
         if (wrEn && wrAddrReg == sao_pkg::ADDR_HYST) begin
            hysReg <= CNT_W'(clampVal(wVal, sao_pkg::HYS_MIN, sao_pkg::HYS_MAX));
         end
         if (wrEn && wrAddrReg == sao_pkg::ADDR_ONDLY) begin
            onDlyReg <= CNT_W'(clampVal(wVal, 0, sao_pkg::DLY_MAX));
         end
         if (wrEn && wrAddrReg == sao_pkg::ADDR_OFFDLY) begin
            offDlyReg <= CNT_W'(clampVal(wVal, 0, sao_pkg::DLY_MAX));
         end
         if (wrEn && wrAddrReg == sao_pkg::ADDR_IRQMSK) begin
            irqMskReg <= hwdata[sao_pkg::IRQ_W-1:0];
         end
      end
   end

   // sampling, timing and outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         btnReg <= 1'b0;
         btnPrevReg <= 1'b0;
         usrReg <= 1'b0;
         usrPrevReg <= 1'b0;
         onLvlReg <= 1'b0;
         offLvlReg <= 1'b0;
         tickCntReg <= 32'h0;
         stReg <= ST_INIT;
         pendReg <= 1'b0;
         alarmOut <= 1'b0;
         backlightColour <= 1'b0;
         irqStReg <= '0;
         irq <= 1'b0;
      end else begin
         btnReg <= rstButton;
         btnPrevReg <= btnReg;
         usrReg <= userReset;
         usrPrevReg <= usrReg;
         if (measTick) begin
            onLvlReg <= onCond;
            offLvlReg <= offCond;
         end
         tickCntReg <= tenthTick ? 32'h0 : tickCntReg + 32'h1;
         stReg <= stNext;
         pendReg <= pendNext;
         alarmOut <= (stNext == ST_ON);
         backlightColour <= baseCol ^ (cfolBit && (stNext == ST_ON));
         irqStReg <= irqStNext;
         irq <= |(irqStNext & irqMskReg);
      end
   end

   // checks
   property p_disabled;
      @(posedge sys_clk) disable iff (!rst_n) !enBit |=> !alarmOut;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled output turned on");

   property p_ondelay;
      @(posedge sys_clk) disable iff (!rst_n) (stReg == ST_OFF) && !onDone |=> !alarmOut;
   endproperty
   a_ondelay: assert property (p_ondelay) else $error("output on before delay ended");

   property p_autohold;
      @(posedge sys_clk) disable iff (!rst_n)
         enBit && (stReg == ST_ON) && rmAuto && !offDone && !manualReq |=> alarmOut;
   endproperty
   a_autohold: assert property (p_autohold) else $error("output off before off delay");

   property p_latch;
      @(posedge sys_clk) disable iff (!rst_n) enBit && (stReg == ST_ON) && rmNow && !manualReq |=> alarmOut;
   endproperty
   a_latch: assert property (p_latch) else $error("latched output dropped");

   property p_latchclr;
      @(posedge sys_clk) disable iff (!rst_n)
         enBit && (stReg == ST_ON) && !rmDefer && manualReq |=> !alarmOut && (stReg == ST_HOLD);
   endproperty
   a_latchclr: assert property (p_latchclr) else $error("manual reset not applied");

   property p_defer;
      @(posedge sys_clk) disable iff (!rst_n)
         enBit && (stReg == ST_ON) && rmDefer && manualReq && !offDone |=> alarmOut && pendReg;
   endproperty
   a_defer: assert property (p_defer) else $error("deferred reset not held");

   property p_standby;
      @(posedge sys_clk) disable iff (!rst_n) (stReg == ST_STBY) && !offLvlReg |=> !alarmOut;
   endproperty
   a_standby: assert property (p_standby) else $error("standby output turned on");

   property p_colour;
      @(posedge sys_clk) disable iff (!rst_n)
         $changed(alarmOut) && $stable(ctrlReg) && ($past(ctrlReg, 2) == ctrlReg) && cfolBit
         |-> $changed(backlightColour);
   endproperty
   a_colour: assert property (p_colour) else $error("colour did not follow output");

   property p_press;
      @(posedge sys_clk) disable iff (!rst_n) btnPress |=> !btnPress;
   endproperty
   a_press: assert property (p_press) else $error("one press gave two pulses");

   property p_sprange;
      @(posedge sys_clk) disable iff (!rst_n) (spReg <= sao_pkg::SP_MAX) && (spReg >= sao_pkg::SP_MIN);
   endproperty
   a_sprange: assert property (p_sprange) else $error("setpoint out of range");

   property p_hysrange;
      @(posedge sys_clk) disable iff (!rst_n) (hysReg >= sao_pkg::HYS_MIN) && (hysReg <= sao_pkg::HYS_MAX);
   endproperty
   a_hysrange: assert property (p_hysrange) else $error("hysteresis out of range");

   property p_dispreset;
      @(posedge sys_clk) disable iff (!rst_n)
         enBit && (stReg == ST_ON) && rmAuto && dispReset && !(rdrBit && dsrcBit && dispShowsInput)
         && !btnPress && !usrPress && !serialReg && !offDone |=> alarmOut;
   endproperty
   a_dispreset: assert property (p_dispreset) else $error("ungated display reset cleared output");
endmodule : sao_top

// ---- verification/sao_relay_model.sv ----
// relay stand-in for the optional output module
`timescale 1ns/1ps
module sao_relay_model #(
   parameter int PICKUP = 3
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // drive from the alarm block
   input wire logic drive,
   // contact state
   output logic relayOn
);
   int settle;
   // contact moves only after the drive has been steady for the pickup time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle <= 0;
         relayOn <= 1'b0;
      end else if (drive == relayOn) begin
         settle <= 0;
      end else if (settle == PICKUP - 1) begin
         relayOn <= drive;
         settle <= 0;
      end else begin
         settle <= settle + 1;
      end
   end
endmodule : sao_relay_model

// ---- verification/setpoint_alarm_output_test.sv ----
// self-checking bench for the setpoint alarm output block
`timescale 1ns/1ps
module setpoint_alarm_output_test;
   localparam int TC = 4;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic measTick = 1'b0;
   logic rstButton = 1'b0;
   logic userReset = 1'b0;
   logic dispReset = 1'b0;
   logic dispShowsInput = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic signed [sao_pkg::VAL_W-1:0] dispValue = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic alarmOut;
   logic backlightColour;
   logic irq;
   logic relayOn;
   logic [31:0] rng = 32'h0000_1892;
   int bad_count = 0;
   int samples_checked = 0;

   sao_top #(.TENTH_CYCLES(TC)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dispValue(dispValue),
      .measTick(measTick), .rstButton(rstButton), .userReset(userReset),
      .dispReset(dispReset), .dispShowsInput(dispShowsInput), .alarmOut(alarmOut),
      .backlightColour(backlightColour), .irq(irq)
   );
   sao_relay_model #(.PICKUP(3)) relay (
      .sys_clk(sys_clk), .rst_n(rst_n), .drive(alarmOut), .relayOn(relayOn)
   );

   always #2.5 sys_clk = ~sys_clk;

   function automatic logic [31:0] nextRnd(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : nextRnd

   function automatic logic [31:0] ctl(input int a, input int rm, input int x);
      return 32'h1 | 32'(a << sao_pkg::CTRL_ACT) | 32'(rm << sao_pkg::CTRL_RMODE) | 32'(x);
   endfunction : ctl

   // next output level from the action, the band and the previous level
   function automatic logic expOut(input int a, input int sp, input int h, input int v, input logic p);
      int lim;
      lim = (a >= 2) ? sp : ((a == 0) ? sp + h : sp - h);
      if (a == 0 || a == 2) begin
         return (v >= lim) ? 1'b1 : ((v <= sp - h) ? 1'b0 : p);
      end
      return (v <= lim) ? 1'b1 : ((v >= sp + h) ? 1'b0 : p);
   endfunction : expOut

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   // one single-word transfer; called just after a rising edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      logic rdy;
      rd = '0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      for (int ph = 0; ph < 2; ph++) begin
         n = 0;
         rdy = 1'b0;
         while (rdy !== 1'b1) begin
            @(posedge sys_clk);
            rdy = hreadyout;
            rd = hrdata;
            n++;
            if (n > 20) begin
               chk(1'b0, "bus hang");
               end_sim();
            end
         end
         if (ph == 0) begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
         end
      end
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] nul;
      ahb(1'b1, a, d, nul);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk(d === e, m);
   endtask : rdChk

   task automatic cfg(input logic [31:0] c, input int sp, input int h, input int dOn, input int dOff);
      wr(sao_pkg::ADDR_CTRL, 32'h0);
      wr(sao_pkg::ADDR_SETPT, 32'(sp));
      wr(sao_pkg::ADDR_HYST, 32'(h));
      wr(sao_pkg::ADDR_ONDLY, 32'(dOn));
      wr(sao_pkg::ADDR_OFFDLY, 32'(dOff));
      wr(sao_pkg::ADDR_CTRL, c);
   endtask : cfg

   task automatic meas(input int v);
      dispValue <= v[sao_pkg::VAL_W-1:0];
      measTick <= 1'b1;
      @(posedge sys_clk);
      measTick <= 1'b0;
      cyc(3);
   endtask : meas

   task automatic chkOut(input logic e, input string m);
      @(negedge sys_clk);
      chk(alarmOut === e, m);
      @(posedge sys_clk);
   endtask : chkOut

   task automatic waitOut(input logic e, input int lim, input string m);
      int n;
      n = 0;
      while (alarmOut !== e && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      cyc(1);
      chk(alarmOut === e, m);
      if (alarmOut !== e) end_sim();
   endtask : waitOut

   // momentary press held for a few cycles
   task automatic press(input logic user);
      if (user) userReset <= 1'b1;
      else rstButton <= 1'b1;
      cyc(4);
      userReset <= 1'b0;
      rstButton <= 1'b0;
      cyc(3);
   endtask : press

   task automatic dispPulse(input logic show);
      dispShowsInput <= show;
      dispReset <= 1'b1;
      cyc(1);
      dispReset <= 1'b0;
      cyc(3);
   endtask : dispPulse

   initial begin
      int sp, h, v, rm;
      int cr[4];
      logic e;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(1);
      rdChk(sao_pkg::ADDR_CTRL, 32'h0, "ctrl rst");
      rdChk(sao_pkg::ADDR_HYST, 32'h1, "hyst rst");
      rdChk(sao_pkg::ADDR_STATUS, 32'h0, "status rst");
      rdChk(8'h24, 32'h0, "unmapped");
      chk(hresp === 1'b0, "hresp");
      wr(sao_pkg::ADDR_SETPT, 32'h0001_86a0);
      rdChk(sao_pkg::ADDR_SETPT, 32'(sao_pkg::SP_MAX), "sp hi");
      wr(sao_pkg::ADDR_SETPT, 32'hffff_b1e0);
      rdChk(sao_pkg::ADDR_SETPT, 32'(sao_pkg::SP_MIN), "sp lo");
      wr(sao_pkg::ADDR_HYST, 32'h0);
      rdChk(sao_pkg::ADDR_HYST, 32'h1, "hys lo");
      wr(sao_pkg::ADDR_HYST, 32'h0000_ea60);
      rdChk(sao_pkg::ADDR_HYST, 32'(sao_pkg::HYS_MAX), "hys hi");
      for (int a = 0; a < 4; a++) begin
         rng = nextRnd(rng);
         sp = int'(rng % 32'd100000) - 19999;
         h = int'(rng[7:0]) + 1;
         cfg(ctl(a, 0, 0) ^ 32'h1, sp, h, 0, 0);
         meas(sp + 3 * h);
         chkOut(1'b0, "disabled hi");
         meas(sp - 3 * h);
         chkOut(1'b0, "disabled lo");
         wr(sao_pkg::ADDR_CTRL, ctl(a, 0, 0));
         cr = '{h, 1 - h, -h, 0};
         e = 1'b0;
         for (int i = 0; i < 12; i++) begin
            rng = nextRnd(rng);
            v = sp + ((i < 4) ? cr[i] : int'(rng % 32'(4 * h + 1)) - 2 * h);
            meas(v);
            e = expOut(a, sp, h, v, e);
            chkOut(e, "action");
         end
      end
      chk(irq === 1'b0, "masked irq");
      cfg(ctl(2, 0, 0), 100, 10, 3, 2);
      meas(95);
      meas(100);
      chkOut(1'b0, "on early");
      cyc(2);
      chkOut(1'b0, "on early");
      meas(95);
      meas(100);
      cyc(2);
      chkOut(1'b0, "no restart");
      waitOut(1'b1, 20, "on late");
      cyc(6);
      chk(relayOn === 1'b1, "relay");
      meas(90);
      chkOut(1'b1, "off early");
      waitOut(1'b0, 16, "off late");
      wr(sao_pkg::ADDR_IRQST, 32'h7);
      for (rm = 0; rm < 4; rm++) begin
         cfg(ctl(2, rm, 1 << sao_pkg::CTRL_CFOL), 100, 10, 0, 0);
         meas(120);
         chkOut(1'b1, "trip");
         chk(backlightColour === 1'b1, "colour on");
         meas(85);
         chkOut(rm != 0, "off point");
         chk(backlightColour === (rm != 0), "colour");
         meas(120);
         chkOut(1'b1, "retrip");
         press(rm == 2);
         chkOut(rm == 2, "press");
         rdChk(sao_pkg::ADDR_STATUS, (rm == 2) ? 32'h13 : 32'h08, "status");
         meas(120);
         chkOut(rm == 2, "held");
         meas(85);
         chkOut(1'b0, "cleared");
         meas(120);
         chkOut(1'b1, "retrigger");
      end
      rdChk(sao_pkg::ADDR_IRQST, 32'h7, "irq status");
      wr(sao_pkg::ADDR_IRQMSK, 32'h1);
      cyc(2);
      chk(irq === 1'b1, "irq up");
      wr(sao_pkg::ADDR_IRQST, 32'h1);
      cyc(2);
      chk(irq === 1'b0, "irq clear");
      rdChk(sao_pkg::ADDR_IRQST, 32'h6, "w1c");
      cfg(ctl(2, 1, 0), 100, 10, 0, 0);
      meas(120);
      wr(sao_pkg::ADDR_CMD, 32'h1);
      cyc(1);
      chkOut(1'b0, "serial reset");
      cfg(ctl(2, 1, (1 << sao_pkg::CTRL_RDR) | (1 << sao_pkg::CTRL_DSRC)), 100, 10, 0, 0);
      meas(120);
      dispPulse(1'b0);
      chkOut(1'b1, "disp hidden");
      dispPulse(1'b1);
      chkOut(1'b0, "disp reset");
      cfg(ctl(2, 2, 0), 100, 10, 0, 0);
      meas(120);
      press(1'b0);
      chkOut(1'b1, "pending");
      rst_n <= 1'b0;
      cyc(2);
      chk(alarmOut === 1'b0, "reset off");
      rst_n <= 1'b1;
      cyc(1);
      rdChk(sao_pkg::ADDR_STATUS, 32'h0, "power cycle");
      cfg(ctl(2, 0, 1 << sao_pkg::CTRL_STBY), 100, 10, 0, 0);
      meas(120);
      chkOut(1'b0, "standby");
      rdChk(sao_pkg::ADDR_STATUS, 32'h04, "standby status");
      meas(85);
      meas(120);
      chkOut(1'b1, "after standby");
      end_sim();
   end
endmodule : setpoint_alarm_output_test
